// ===== design/batch_setpoint_sequencer.sv
// module: setpoint engine with batch sequencer and avalon-mm slave
// Overview of operation
// - continuous setpoints re-evaluated at every converter update, outputs follow condition
// - batch steps run one after another in index order, up to 32
// - batch output active until condition met, then latched until sequence ends
// - batching only when enabled; auto restarts, manual waits for start
// - start accepted from digital input, serial command or softkey
// - dual-use kind joins batch only with its batch flag set
// - batch-only kinds join the sequence without the batch flag
// - gross kind compares gross weight with positive target
// - net kind compares net weight with positive target
// - negative kinds compare gross or net with negated target
// - accumulator kind compares source accumulator total with value
// - rate-change kind compares rate of change of weight
// - plus-relative target is referenced target plus value, referenced mode
// - minus-relative target is referenced target minus value, referenced mode
// - percent-relative target is percentage of referenced target
// - captured-relative target is percentage of referenced captured value
// - pause step halts sequence until a new start
// - delay step holds for value tenths of a second then advances
// - standstill step waits for standstill then advances
// - counter step limits number of consecutive sequences
// - batch-progress setpoint output active while any sequence runs
`timescale 1ns/100ps
`default_nettype none
module batch_setpoint_sequencer (
	input  wire logic                  ref_clk,      // 40 mhz clock
	input  wire logic                  srst,         // sync reset, active high
	input  wire logic [9:0]            address,      // avalon byte address
	input  wire logic                  read,         // avalon read
	input  wire logic                  write,        // avalon write
	input  wire logic [31:0]           writedata,    // avalon write data
	input  wire logic [3:0]            byteenable,   // avalon byte enables
	output logic [31:0]                readdata,     // avalon read data
	output logic                       waitrequest,  // avalon wait
	input  wire setpoint_pkg::scale_t  scale_in,     // weight values, same domain
	input  wire logic                  conv_update,  // converter update pulse
	input  wire logic                  start_pin,    // digital input start, async
	input  wire logic                  start_serial, // serial command start pulse
	input  wire logic                  start_softkey,// softkey start pulse
	output logic [31:0]                dig_out,      // digital outputs
	output logic                       batch_busy    // sequence in progress
);
	localparam int unsigned N = setpoint_pkg::NUM_SP;
	localparam int unsigned W = setpoint_pkg::W_WIDTH;

	setpoint_pkg::sp_cfg_t     cfg_q [N];
	logic signed [W-1:0]       val_q [N];
	logic signed [W-1:0]       capt_q [N];
	logic [31:0]               ctrl_q;
	logic [N-1:0]              met_q;
	logic [N-1:0]              latch_q;
	logic [4:0]                step_q;
	logic [15:0]               count_q;
	logic                      count_set_q;
	logic [W-1:0]              delay_q;
	logic [22:0]               tick_cnt_q;
	logic                      tick_q;
	logic [1:0]                pin_sync_q;
	logic                      pin_prev_q;
	logic                      sw_start_q;
	logic                      start_d;
	logic                      upd_q;
	logic [N-1:0]              in_batch;
	logic [N-1:0]              cond;
	logic [31:0]               out_d;
	setpoint_pkg::seq_state_t  state_q;

	function automatic logic dual_use(input setpoint_pkg::sp_kind_t k);
		dual_use = (k >= setpoint_pkg::K_GROSS) && (k <= setpoint_pkg::K_CAPREL);
	endfunction

	function automatic logic batch_only(input setpoint_pkg::sp_kind_t k);
		batch_only = (k >= setpoint_pkg::K_PAUSE) && (k <= setpoint_pkg::K_COUNTER);
	endfunction

	function automatic logic signed [W-1:0] pct(input logic signed [W-1:0] base,
						    input logic signed [W-1:0] p);
		logic signed [2*W-1:0] prod;
		prod = base * p;
		pct = W'(prod / 100);
	endfunction

	function automatic logic signed [W-1:0] mode_val(input setpoint_pkg::sp_kind_t k,
							 input setpoint_pkg::scale_t s);
		unique case (k)
			setpoint_pkg::K_NET, setpoint_pkg::K_NNET: mode_val = s.net;
			setpoint_pkg::K_ACCUMULATOR_COMPARE_KIND:                     mode_val = s.accumulator_compare_kind;
			setpoint_pkg::K_RATE:                      mode_val = s.rate;
			default:                                   mode_val = s.gross;
		endcase
	endfunction

	// start sources, pin synchronised then edge detected
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pin_sync_q <= 2'h0;
			pin_prev_q <= 1'b0;
		end else begin
			pin_sync_q <= {pin_sync_q[0], start_pin};
			pin_prev_q <= pin_sync_q[1];
		end
	end
	assign start_d = (pin_sync_q[1] & ~pin_prev_q) | start_serial | start_softkey | sw_start_q;

	// 100 ms time base
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tick_cnt_q <= 23'h0;
			tick_q     <= 1'b0;
		end else if (state_q != setpoint_pkg::S_DELAY) begin
			tick_cnt_q <= 23'h0; // restart so a delay counts whole ticks
			tick_q     <= 1'b0;
		end else if (tick_cnt_q == 23'(setpoint_pkg::TICK_CYCLES - 1)) begin
			tick_cnt_q <= 23'h0;
			tick_q     <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 23'h1;
			tick_q     <= 1'b0;
		end
	end

	// batch membership and conditions
	always_comb begin
		for (int i = 0; i < N; i++) begin
			in_batch[i] = batch_only(cfg_q[i].kind)
				| (dual_use(cfg_q[i].kind) & cfg_q[i].batch);
		end
	end

	always_comb begin
		for (int i = 0; i < N; i++) begin
			logic signed [W-1:0]      tgt;
			setpoint_pkg::sp_kind_t   mk;
			setpoint_pkg::sp_kind_t   rk;
			logic signed [W-1:0]      rv;
			logic signed [W-1:0]      meas;
			tgt  = val_q[i];
			mk   = cfg_q[i].kind;
			rk   = cfg_q[cfg_q[i].ref_sp].kind;
			rv   = (rk == setpoint_pkg::K_NGROSS || rk == setpoint_pkg::K_NNET)
				? -val_q[cfg_q[i].ref_sp] : val_q[cfg_q[i].ref_sp];
			unique case (cfg_q[i].kind)
				setpoint_pkg::K_NGROSS, setpoint_pkg::K_NNET: tgt = -val_q[i];
				setpoint_pkg::K_PREL: begin
					tgt = rv + val_q[i];
					mk  = rk;
				end
				setpoint_pkg::K_MREL: begin
					tgt = rv - val_q[i];
					mk  = rk;
				end
				setpoint_pkg::K_PCTREL: begin
					tgt = pct(rv, val_q[i]);
					mk  = rk;
				end
				setpoint_pkg::K_CAPREL: begin
					tgt = pct(capt_q[cfg_q[i].ref_sp], val_q[i]);
					mk  = rk;
				end
				default: tgt = val_q[i];
			endcase
			meas = mode_val(mk, scale_in);
			cond[i] = cfg_q[i].below ? (meas <= tgt) : (meas >= tgt);
			if (cfg_q[i].kind == setpoint_pkg::K_OFF) begin
				cond[i] = 1'b0;
			end
		end
	end

	// update strobe registered so strobe and condition snapshot align
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			upd_q <= 1'b0;
		end else begin
			upd_q <= conv_update;
		end
	end

	// condition snapshots on each update, captured values on an update where a condition first becomes met
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			met_q <= '0;
		end else if (conv_update) begin
			met_q <= cond;
		end
	end

	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < N; i++) begin
			if (conv_update && cond[i] && !met_q[i]) begin
				capt_q[i] <= mode_val(cfg_q[i].kind, scale_in);
			end
		end
	end

	// batch sequencer
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_q     <= setpoint_pkg::S_IDLE;
			step_q      <= 5'h0;
			latch_q     <= '0;
			delay_q     <= '0;
			count_q     <= 16'h0;
			count_set_q <= 1'b0;
		end else if (!ctrl_q[setpoint_pkg::CTRL_EN_BIT]) begin
			state_q     <= setpoint_pkg::S_IDLE;
			latch_q     <= '0;
			count_set_q <= 1'b0;
		end else begin
			unique case (state_q)
				setpoint_pkg::S_IDLE: begin
					if (ctrl_q[setpoint_pkg::CTRL_AUTO_BIT] || start_d) begin
						state_q <= setpoint_pkg::S_STEP;
						step_q  <= 5'h0;
						latch_q <= '0;
					end
				end
				setpoint_pkg::S_STEP: begin
					if (!in_batch[step_q]) begin
						if (step_q == 5'(N - 1)) begin
							state_q <= setpoint_pkg::S_END;
						end else begin
							step_q <= step_q + 5'h1;
						end
					end else begin
						unique case (cfg_q[step_q].kind)
							setpoint_pkg::K_PAUSE: state_q <= setpoint_pkg::S_PAUSE;
							setpoint_pkg::K_DELAY: begin
								delay_q <= val_q[step_q];
								state_q <= setpoint_pkg::S_DELAY;
							end
							setpoint_pkg::K_STANDSTILL_WAIT_KIND: begin
								if (scale_in.standstill) begin
									latch_q[step_q] <= 1'b1;
									state_q <= (step_q == 5'(N - 1)) ? setpoint_pkg::S_END
										: setpoint_pkg::S_STEP;
									step_q  <= step_q + 5'h1;
								end
							end
							setpoint_pkg::K_COUNTER: begin
								if (!count_set_q) begin
									count_q     <= 16'(val_q[step_q]);
									count_set_q <= 1'b1;
								end
								state_q <= (step_q == 5'(N - 1)) ? setpoint_pkg::S_END
									: setpoint_pkg::S_STEP;
								step_q  <= step_q + 5'h1;
							end
							default: begin
								if (upd_q && met_q[step_q]) begin
									latch_q[step_q] <= 1'b1;
									state_q <= (step_q == 5'(N - 1)) ? setpoint_pkg::S_END
										: setpoint_pkg::S_STEP;
									step_q  <= step_q + 5'h1;
								end
							end
						endcase
					end
				end
				setpoint_pkg::S_PAUSE: begin
					if (start_d) begin
						state_q <= (step_q == 5'(N - 1)) ? setpoint_pkg::S_END
							: setpoint_pkg::S_STEP;
						step_q  <= step_q + 5'h1;
					end
				end
				setpoint_pkg::S_DELAY: begin
					if (delay_q <= 0) begin
						state_q <= (step_q == 5'(N - 1)) ? setpoint_pkg::S_END
							: setpoint_pkg::S_STEP;
						step_q  <= step_q + 5'h1;
					end else if (tick_q) begin
						delay_q <= delay_q - W'(1);
					end
				end
				setpoint_pkg::S_END: begin
					latch_q <= '0;
					state_q <= setpoint_pkg::S_IDLE;
					if (count_set_q) begin
						if (count_q <= 16'h1) begin
							count_set_q <= 1'b0;
						end else begin
							count_q <= count_q - 16'h1;
							state_q <= setpoint_pkg::S_STEP;
							step_q  <= 5'h0;
						end
					end
				end
				default: state_q <= setpoint_pkg::S_IDLE;
			endcase
		end
	end
	// counter exhaustion in auto mode stops the repeat
	logic count_done;
	assign count_done = (state_q == setpoint_pkg::S_END) && count_set_q && (count_q <= 16'h1);
	// output drive
	always_comb begin
		out_d = '0;
		for (int i = 0; i < N; i++) begin
			if (cfg_q[i].kind == setpoint_pkg::K_PROGRESS) begin
				out_d[cfg_q[i].out_sel] = out_d[cfg_q[i].out_sel]
					| (state_q != setpoint_pkg::S_IDLE);
			end else if (in_batch[i] && !batch_only(cfg_q[i].kind)) begin
				out_d[cfg_q[i].out_sel] = out_d[cfg_q[i].out_sel]
					| ((state_q == setpoint_pkg::S_STEP) && (step_q == 5'(i)) && !latch_q[i]);
			end else if (cfg_q[i].kind != setpoint_pkg::K_OFF && !batch_only(cfg_q[i].kind)) begin
				out_d[cfg_q[i].out_sel] = out_d[cfg_q[i].out_sel] | met_q[i];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			dig_out    <= 32'h0;
			batch_busy <= 1'b0;
		end else begin
			dig_out    <= out_d;
			batch_busy <= (state_q != setpoint_pkg::S_IDLE);
		end
	end

	// avalon-mm slave, one wait cycle per access, answer from a flop
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= ~((read | write) & waitrequest);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl_q     <= setpoint_pkg::CTRL_RESET;
			sw_start_q <= 1'b0;
			for (int i = 0; i < N; i++) begin
				cfg_q[i] <= '0;
				val_q[i] <= '0;
			end
		end else begin
			sw_start_q <= 1'b0;
			if (count_done && ctrl_q[setpoint_pkg::CTRL_AUTO_BIT]) begin
				ctrl_q[setpoint_pkg::CTRL_EN_BIT] <= 1'b0;
			end
			if (write && !waitrequest && byteenable[0]) begin
				if (address == setpoint_pkg::OFS_CTRL) begin
					ctrl_q <= {30'h0, writedata[1:0]};
				end else if (address == setpoint_pkg::OFS_START) begin
					sw_start_q <= writedata[0];
				end else if (address[9:7] == setpoint_pkg::OFS_CFG_BASE[9:7]) begin
					cfg_q[address[6:2]] <= '{
						out_sel: writedata[setpoint_pkg::CFG_OUT_LSB +: 5],
						ref_sp:  writedata[setpoint_pkg::CFG_REF_LSB +: 5],
						below:   writedata[setpoint_pkg::CFG_BELOW_BIT],
						batch:   writedata[setpoint_pkg::CFG_BATCH_BIT],
						kind:    setpoint_pkg::sp_kind_t'(writedata[setpoint_pkg::CFG_KIND_LSB +: 4])
					};
				end else if (address[9:7] == setpoint_pkg::OFS_VAL_BASE[9:7]) begin
					val_q[address[6:2]] <= writedata[W-1:0];
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			readdata <= 32'h0;
		end else if (read && waitrequest) begin
			if (address == setpoint_pkg::OFS_CTRL) begin
				readdata <= ctrl_q;
			end else if (address == setpoint_pkg::OFS_STATUS) begin
				readdata <= {16'h0, count_q[7:0], 2'h0, 1'b0, step_q} | {27'h0, 5'h0};
			end else if (address == setpoint_pkg::OFS_OUTS) begin
				readdata <= dig_out;
			end else if (address[9:7] == setpoint_pkg::OFS_CAPT_BASE[9:7]) begin
				readdata <= 32'(capt_q[address[6:2]]);
			end else if (address[9:7] == setpoint_pkg::OFS_CFG_BASE[9:7]) begin
				readdata <= {11'h0, cfg_q[address[6:2]].out_sel, 3'h0, cfg_q[address[6:2]].ref_sp, 2'h0,
					cfg_q[address[6:2]].below, cfg_q[address[6:2]].batch, cfg_q[address[6:2]].kind};
			end else if (address[9:7] == setpoint_pkg::OFS_VAL_BASE[9:7]) begin
				readdata <= 32'(val_q[address[6:2]]);
			end else begin
				readdata <= 32'h0;
			end
		end
	end
endmodule
`default_nettype wire

// ===== design/setpoint_pkg.sv
// package: setpoint engine constants, types and register map
package setpoint_pkg;
	localparam int unsigned CLK_HZ        = 40000000;
	localparam int unsigned TICK_MS       = 100;
	localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned NUM_SP        = 32;
	localparam int unsigned W_WIDTH       = 24;

	// register offsets (byte addresses)
	localparam logic [9:0] OFS_CTRL       = 10'h000;
	localparam logic [9:0] OFS_STATUS     = 10'h004;
	localparam logic [9:0] OFS_START      = 10'h008;
	localparam logic [9:0] OFS_OUTS       = 10'h00c;
	localparam logic [9:0] OFS_CAPT_BASE  = 10'h080;
	localparam logic [9:0] OFS_CFG_BASE   = 10'h100;
	localparam logic [9:0] OFS_VAL_BASE   = 10'h200;

	// ctrl fields
	localparam int unsigned CTRL_EN_BIT   = 0;
	localparam int unsigned CTRL_AUTO_BIT = 1;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

	// per-setpoint config word fields
	localparam int unsigned CFG_KIND_LSB  = 0;
	localparam int unsigned CFG_BATCH_BIT = 4;
	localparam int unsigned CFG_BELOW_BIT = 5;
	localparam int unsigned CFG_REF_LSB   = 8;
	localparam int unsigned CFG_OUT_LSB   = 16;

	typedef enum logic [3:0] {
		K_OFF      = 4'h0,
		K_GROSS    = 4'h1,
		K_NET      = 4'h2,
		K_NGROSS   = 4'h3,
		K_NNET     = 4'h4,
		K_ACCUMULATOR_COMPARE_KIND    = 4'h5,
		K_RATE     = 4'h6,
		K_PREL     = 4'h7,
		K_MREL     = 4'h8,
		K_PCTREL   = 4'h9,
		K_CAPREL   = 4'ha,
		K_PAUSE    = 4'hb,
		K_DELAY    = 4'hc,
		K_STANDSTILL_WAIT_KIND   = 4'hd,
		K_COUNTER  = 4'he,
		K_PROGRESS = 4'hf
	} sp_kind_t;

	typedef struct packed {
		logic [4:0]  out_sel;
		logic [4:0]  ref_sp;
		logic        below;
		logic        batch;
		sp_kind_t    kind;
	} sp_cfg_t;

	typedef struct packed {
		logic signed [W_WIDTH-1:0] gross;
		logic signed [W_WIDTH-1:0] net;
		logic signed [W_WIDTH-1:0] accumulator_compare_kind;
		logic signed [W_WIDTH-1:0] rate;
		logic                      standstill;
	} scale_t;

	typedef enum logic [4:0] {
		S_IDLE  = 5'b00001,
		S_STEP  = 5'b00010,
		S_PAUSE = 5'b00100,
		S_DELAY = 5'b01000,
		S_END   = 5'b10000
	} seq_state_t;
endpackage

// ===== testbench/batch_setpoint_sequencer_bench.sv
// bench: setpoint sequencer with feeder partner and register checks
`timescale 1ns/100ps
`default_nettype none
module batch_setpoint_sequencer_bench;
	logic                 ref_clk       = 1'b0;
	logic                 srst          = 1'b1;
	logic [9:0]           address       = 10'h0;
	logic                 read          = 1'b0;
	logic                 write         = 1'b0;
	logic [31:0]          writedata     = 32'h0;
	logic                 start_pin     = 1'b0;
	logic                 start_serial  = 1'b0;
	logic                 start_softkey = 1'b0;
	logic                 load          = 1'b0;
	logic                 shake         = 1'b0;
	logic signed [23:0]   load_gross    = 24'h0;
	logic signed [23:0]   net_in        = 24'h0;
	logic [31:0]          readdata;
	logic                 waitrequest;
	logic [31:0]          dig_out;
	logic                 batch_busy;
	logic                 conv_update;
	setpoint_pkg::scale_t scale;
	logic [32:0]          obs;
	logic [31:0]          exp_q[$];
	logic [23:0]          tgt;
	int                   n_fail        = 0;
	int                   cmp_count     = 0;
	int                   seed;
	assign obs = {batch_busy, dig_out};
	always #12.5 ref_clk = ~ref_clk;
	batch_setpoint_sequencer dut_u (.ref_clk(ref_clk), .srst(srst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
		.waitrequest(waitrequest), .scale_in(scale), .conv_update(conv_update), .start_pin(start_pin),
		.start_serial(start_serial), .start_softkey(start_softkey), .dig_out(dig_out), .batch_busy(batch_busy));
	feeder_model feed_u (.ref_clk(ref_clk), .srst(srst), .feed(dig_out[2]), .shake(shake), .load(load),
		.load_gross(load_gross), .net_in(net_in), .scale(scale), .conv_update(conv_update));
	task automatic test_done;
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
		int n;
		n = 0;
		address   <= a;
		writedata <= d;
		read      <= !wr;
		write     <= wr;
		do begin
			@(posedge ref_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		read  <= 1'b0;
		write <= 1'b0;
		@(posedge ref_clk);
		if (n >= 50) begin
			n_fail++;
			test_done;
		end
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic set_w(input logic [23:0] g, input logic [23:0] n);
		load_gross <= g;
		net_in     <= n;
		load       <= 1'b1;
		@(posedge ref_clk);
		load <= 1'b0;
		@(posedge ref_clk);
	endtask
	// wait up to lim cycles for an output level, then compare
	task automatic check(input int b, input logic v, input int lim);
		int n;
		n = 0;
		while (obs[b] !== v && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		cmp_count++;
		if (obs[b] !== v) begin
			n_fail++;
			$display("BAD out%0d exp %b got %b", b, v, obs[b]);
			if (lim > 0)
				test_done;
		end
	endtask
	// start source: 0 serial, 1 softkey, 2 pin, 3 register
	task automatic go(input int s);
		if (s == 3)
			bus(1'b1, setpoint_pkg::OFS_START, 32'h1);
		start_serial  <= (s == 0);
		start_softkey <= (s == 1);
		start_pin     <= (s == 2);
		@(posedge ref_clk);
		start_serial  <= 1'b0;
		start_softkey <= 1'b0;
		repeat (3) @(posedge ref_clk);
		start_pin <= 1'b0;
	endtask
	function automatic logic [31:0] cfg(input setpoint_pkg::sp_kind_t k, input logic b, input logic bl,
		input logic [4:0] o);
		return {11'h0, o, 10'h0, bl, b, k};
	endfunction
	always @(posedge ref_clk) begin
		if (read === 1'b1 && waitrequest === 1'b0 && exp_q.size() > 0) begin
			cmp_count++;
			if (readdata !== exp_q[0])
				$display("BAD readdata exp %h got %h", exp_q[0], readdata);
			if (readdata !== exp_q[0])
				n_fail++;
			void'(exp_q.pop_front());
		end
	end
	initial begin
		seed = 32'h256f6436;
		repeat (6) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		rd(setpoint_pkg::OFS_CTRL, setpoint_pkg::CTRL_RESET);
		rd(setpoint_pkg::OFS_STATUS, 32'h0);
		rd(setpoint_pkg::OFS_OUTS, 32'h0);
		bus(1'b1, 10'h300, 32'hffffffff);
		rd(10'h300, 32'h0);
		tgt = 24'(100 + $unsigned($random(seed)) % 100);
		bus(1'b1, setpoint_pkg::OFS_VAL_BASE, 32'(tgt));
		bus(1'b1, setpoint_pkg::OFS_CFG_BASE, cfg(setpoint_pkg::K_GROSS, 1'b0, 1'b0, 5'd0));
		bus(1'b1, setpoint_pkg::OFS_VAL_BASE + 10'h4, 32'd100);
		bus(1'b1, setpoint_pkg::OFS_CFG_BASE + 10'h4, cfg(setpoint_pkg::K_NNET, 1'b0, 1'b1, 5'd1));
		rd(setpoint_pkg::OFS_CFG_BASE + 10'h4, cfg(setpoint_pkg::K_NNET, 1'b0, 1'b1, 5'd1));
		bus(1'b1, setpoint_pkg::OFS_VAL_BASE + 10'h18, 32'h1);
		bus(1'b1, setpoint_pkg::OFS_CFG_BASE + 10'h18, cfg(setpoint_pkg::K_PREL, 1'b0, 1'b0, 5'd6));
		bus(1'b1, setpoint_pkg::OFS_VAL_BASE + 10'h1c, 32'h1);
		bus(1'b1, setpoint_pkg::OFS_CFG_BASE + 10'h1c, cfg(setpoint_pkg::K_MREL, 1'b0, 1'b0, 5'd7));
		bus(1'b1, setpoint_pkg::OFS_VAL_BASE + 10'h20, 32'hc8);
		bus(1'b1, setpoint_pkg::OFS_CFG_BASE + 10'h20, cfg(setpoint_pkg::K_PCTREL, 1'b0, 1'b0, 5'd8));
		set_w(tgt - 24'd1, -24'sd99);
		check(0, 1'b0, 200);
		check(1, 1'b0, 200);
		set_w(tgt, -24'sd100);
		check(0, 1'b1, 200);
		check(1, 1'b1, 200);
		check(6, 1'b0, 0);
		set_w(tgt + 24'd1, -24'sd100);
		check(6, 1'b1, 200);
		set_w(tgt - 24'd1, 24'sd0);
		check(0, 1'b0, 200);
		check(1, 1'b0, 200);
		check(7, 1'b1, 0);
		set_w(tgt - 24'd2, 24'sd0);
		check(7, 1'b0, 200);
		set_w(tgt + tgt, 24'sd0);
		check(8, 1'b1, 200);
		set_w(tgt + tgt - 24'd1, 24'sd0);
		check(8, 1'b0, 200);
		bus(1'b1, setpoint_pkg::OFS_VAL_BASE + 10'h8, 32'd200);
		bus(1'b1, setpoint_pkg::OFS_CFG_BASE + 10'h8, cfg(setpoint_pkg::K_GROSS, 1'b1, 1'b0, 5'd2));
		bus(1'b1, setpoint_pkg::OFS_CFG_BASE + 10'hc, cfg(setpoint_pkg::K_PAUSE, 1'b0, 1'b0, 5'd3));
		bus(1'b1, setpoint_pkg::OFS_CFG_BASE + 10'h10, cfg(setpoint_pkg::K_STANDSTILL_WAIT_KIND, 1'b0, 1'b0, 5'd4));
		bus(1'b1, setpoint_pkg::OFS_CFG_BASE + 10'h14, cfg(setpoint_pkg::K_PROGRESS, 1'b0, 1'b0, 5'd5));
		go(0);
		repeat (40) @(posedge ref_clk);
		check(32, 1'b0, 0);
		bus(1'b1, setpoint_pkg::OFS_CTRL, 32'h1);
		for (int s = 0; s < 4; s++) begin
			set_w(24'h0, 24'h0);
			go(s);
			check(32, 1'b1, 50);
			check(5, 1'b1, 50);
			check(2, 1'b1, 50);
			shake <= 1'b1;
			check(2, 1'b0, 600);
			check(0, 1'b1, 50);
			set_w(24'h0, 24'h0);
			check(0, 1'b0, 200);
			check(2, 1'b0, 0);
			check(32, 1'b1, 0);
			go(1);
			repeat (40) @(posedge ref_clk);
			check(32, 1'b1, 0);
			shake <= 1'b0;
			check(32, 1'b0, 100);
			check(5, 1'b0, 20);
		end
		// auto mode with a repeat count of two, then auto stop
		bus(1'b1, setpoint_pkg::OFS_VAL_BASE + 10'hc, 32'h2);
		bus(1'b1, setpoint_pkg::OFS_CFG_BASE + 10'hc, cfg(setpoint_pkg::K_COUNTER, 1'b0, 1'b0, 5'd3));
		set_w(24'h0, 24'h0);
		bus(1'b1, setpoint_pkg::OFS_CTRL, 32'h3);
		check(2, 1'b1, 50);
		check(2, 1'b0, 600);
		check(2, 1'b1, 100);
		check(32, 1'b0, 100);
		repeat (40) @(posedge ref_clk);
		check(32, 1'b0, 0);
		rd(setpoint_pkg::OFS_CTRL, 32'h2);
		test_done;
	end
endmodule
`default_nettype wire

// ===== testbench/batch_setpoint_sequencer_properties.sv
// checker: port properties of the setpoint sequencer
`timescale 1ns/100ps
`default_nettype none
module sequencer_checker (
	input wire logic        ref_clk,       // clock
	input wire logic        srst,          // sync reset
	input wire logic [9:0]  address,       // bus address
	input wire logic        read,          // bus read
	input wire logic        write,         // bus write
	input wire logic [31:0] writedata,     // bus write data
	input wire logic [31:0] readdata,      // bus read data
	input wire logic        waitrequest,   // bus wait
	input wire logic        conv_update,   // converter update
	input wire logic        start_serial,  // serial start
	input wire logic        start_softkey, // softkey start
	input wire logic [31:0] dig_out,       // outputs
	input wire logic        batch_busy     // sequence running
);
	logic       en_q;
	logic       auto_q;
	logic [3:0] age_q;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			en_q   <= 1'b0;
			auto_q <= 1'b0;
		end else if (write && !waitrequest && address == setpoint_pkg::OFS_CTRL) begin
			en_q   <= writedata[0];
			auto_q <= writedata[1];
		end
	end
	// cycles since the last converter update
	always_ff @(posedge ref_clk) begin
		if (srst || conv_update)
			age_q <= 4'h0;
		else if (age_q != 4'hf)
			age_q <= age_q + 4'h1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	answer_late_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("bus answer missing after one wait");
	answer_once_a: assert property (!waitrequest |=> waitrequest)
		else $error("bus answer held too long");
	idle_wait_a: assert property (!read && !write |-> waitrequest)
		else $error("bus answer without request");
	unmapped_zero_a: assert property (read && !waitrequest && address >= 10'h300 |-> readdata == 32'h0)
		else $error("unmapped read not zero");
	reset_quiet_a: assert property (disable iff (1'b0) srst |=> dig_out == 32'h0 && !batch_busy)
		else $error("outputs not cleared by reset");
	batch_enable_a: assert property ($rose(batch_busy) |-> en_q)
		else $error("sequence ran while batching off");
	manual_start_a: assert property (en_q && !auto_q && !batch_busy && (start_serial || start_softkey)
		|-> ##[1:4] batch_busy)
		else $error("start not taken");
	cont_follow_a: assert property (!batch_busy && !$past(batch_busy) && !$past(batch_busy, 2)
		&& $changed(dig_out) |-> age_q < 4'h8)
		else $error("continuous output moved without update");
	run_end_c: cover property (batch_busy ##1 !batch_busy);
	run_start_c: cover property (start_serial && !batch_busy ##[1:4] batch_busy);
	unmapped_c: cover property (read && !waitrequest && address >= 10'h300);
endmodule
bind batch_setpoint_sequencer sequencer_checker chk_u (.ref_clk(ref_clk), .srst(srst), .address(address),
	.read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
	.conv_update(conv_update), .start_serial(start_serial), .start_softkey(start_softkey),
	.dig_out(dig_out), .batch_busy(batch_busy));
`default_nettype wire

// ===== testbench/feeder_model.sv
// partner: feeder and scale whose gross weight rises while fed
`timescale 1ns/100ps
`default_nettype none
module feeder_model (
	input  wire logic               ref_clk,    // clock
	input  wire logic               srst,       // sync reset
	input  wire logic               feed,       // feeder drive from an output
	input  wire logic               shake,      // keeps the scale in motion
	input  wire logic               load,       // take preset weights
	input  wire logic signed [23:0] load_gross, // preset gross
	input  wire logic signed [23:0] net_in,     // net weight
	output var setpoint_pkg::scale_t scale,     // weight values
	output logic                    conv_update // converter update pulse
);
	logic [3:0] div_q;
	always_ff @(posedge ref_clk) begin
		div_q       <= srst ? 4'h0 : div_q + 4'h1;
		conv_update <= !srst && div_q == 4'hf;
	end
	always_ff @(posedge ref_clk) begin
		if (srst || load)
			scale.gross <= load_gross;
		else if (feed && conv_update)
			scale.gross <= scale.gross + 24'sd16;
		scale.net        <= net_in;
		scale.accumulator_compare_kind      <= '0;
		scale.rate       <= '0;
		scale.standstill <= !feed && !shake;
	end
endmodule
`default_nettype wire
